// ==== logic/vbir_cfg.svh ====
// Purpose: Constants of the video buffer interrupt router
// Assumes: Included by its bare name
// Notes:   Offsets are byte addresses on the plain register port
//
// Overview of operation
// [R01] Thirteen sticky flags in bits 0 to 12 are set by their source and held until cleared.
// [R02] Writing a one to a flag bit clears that flag.
// [R03] The selector in bits 31 to 28 of the interrupt select word steers interrupt line 7.
// [R04] Lower 4-bit selectors steer lines 6 down to 0, bits 27 to 24 being line 6.
// [R05] Codes 0-2 capture syncs, 3 statistics, 4 encoder, 5 display, 6 pipe input, 7-10 and 12 pipe.
// [R06] Four event selectors in the upper half of the event word steer event lines 3 to 0; here bits 31 to 28 read as fixed code 13, so event line 3 never pulses.
// [R07] Bits 3 to 0 of the event word select the source of a ninth interrupt line.
// [R08] Memory select bit 2 set limits pipe write starts to 32-byte boundaries.
// [R09] Memory select bit 1 gives the resizer memory to the pipe when zero; one is reserved.
// [R10] Memory select bit 0 gives the defect memory to the pipe at zero, to capture at one.
// [R11] Zero bits of a clear write leave flags alone; codes 11 and 13 to 15 drive nothing.
// [R12] Each line pulses one cycle whenever its selected source triggers.
`ifndef VBIR_CFG_SVH
`define VBIR_CFG_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define VBIR_OFS_FLAG    8'h0c
`define VBIR_OFS_ISEL    8'h10
`define VBIR_OFS_ESEL    8'h14
`define VBIR_OFS_MSEL    8'h18
`define VBIR_OFS_MASK    8'h1c

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define VBIR_RST_ISEL    32'h76543210
`define VBIR_RST_EVT3    4'hd
`define VBIR_RST_EVT2    4'hb
`define VBIR_RST_EVT1    4'h8
`define VBIR_RST_EVT0    4'h3
`define VBIR_RST_INT8    4'h8
`define VBIR_RST_MSEL    3'h0
`define VBIR_RST_MASK    13'h0000
`define VBIR_RST_FLAG    13'h0000

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define VBIR_ESEL_EVT_LSB  16
`define VBIR_ESEL_INT8_LSB 0
`define VBIR_MSEL_ALIGN    2
`define VBIR_MSEL_RSZ      1
`define VBIR_MSEL_DFC      0
`define VBIR_CODE_UNUSED   4'hb

`endif

// ==== logic/vbir_pkg.sv ====
// Purpose: Types of the video buffer interrupt router
// Assumes: Nothing
// Notes:   Widths fixed at the documented values
`default_nettype none
package vbir_pkg;
  localparam int VBIR_NSRC = 13;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } vbir_req_t;

  typedef struct packed {
    logic pipe_write_align_ctl;
    logic resizer_memory_select;
    logic defect_memory_select;
  } vbir_mem_t;

  typedef logic [3:0] vbir_code_t;
endpackage
`default_nettype wire

// ==== logic/vbir_top.sv ====
// Purpose: Sticky flags and line routing of the video buffer logic
// Assumes: Source triggers come from logic on clk_sys
// Notes:   Line outputs lag the trigger by one clock
//
// Our own choices: the address map and the strobed register port.
`include "vbir_cfg.svh"
`default_nettype none
module vbir_top
  import vbir_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire vbir_req_t            req,
  output logic      [31:0]          rdata,
  input  wire logic [VBIR_NSRC-1:0] src_trig,
  output logic      [8:0]           int_line,
  output logic      [3:0]           evt_line,
  output logic                      irq,
  output vbir_mem_t                 mem_sel
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [VBIR_NSRC-1:0] flag_r;
  logic [VBIR_NSRC-1:0] flag_nxt;
  logic [VBIR_NSRC-1:0] mask_r;
  logic [31:0]          isel_r;
  logic [11:0]          esel_r;
  logic [3:0]           int8_r;
  logic [2:0]           msel_r;
  logic [31:0]          rdata_nxt;
  logic [8:0]           int_nxt;
  logic [3:0]           evt_nxt;
  logic                 wr_flag;
  logic                 wr_isel;
  logic                 wr_esel;
  logic                 wr_msel;
  logic                 wr_mask;

  // ------------------------------------------------------------
  // Source decode
  // ------------------------------------------------------------
  // Code 11 has no source although flag 11 exists
  function automatic logic src_of(
    input vbir_code_t           code,
    input logic [VBIR_NSRC-1:0] trig
  );
    logic hit;
    hit = 1'b0;
    if (code != `VBIR_CODE_UNUSED && code < vbir_code_t'(VBIR_NSRC))
    begin
      hit = trig[code];
    end
    return hit;
  endfunction

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  assign wr_flag = req.wr && (req.addr == `VBIR_OFS_FLAG);
  assign wr_isel = req.wr && (req.addr == `VBIR_OFS_ISEL);
  assign wr_esel = req.wr && (req.addr == `VBIR_OFS_ESEL);
  assign wr_msel = req.wr && (req.addr == `VBIR_OFS_MSEL);
  assign wr_mask = req.wr && (req.addr == `VBIR_OFS_MASK);

  // ------------------------------------------------------------
  // Sticky flags
  // ------------------------------------------------------------
  // Set wins over a clear in the same cycle
  always_comb
  begin
    flag_nxt = flag_r;
    if (wr_flag)
    begin
      flag_nxt = flag_r & ~req.wdata[VBIR_NSRC-1:0]; // see [R02] see [R11]
    end
    flag_nxt = flag_nxt | src_trig; // see [R01]
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      flag_r <= `VBIR_RST_FLAG;
    end
    else
    begin
      flag_r <= flag_nxt;
    end
  end

  // ------------------------------------------------------------
  // Selector registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      isel_r <= `VBIR_RST_ISEL;
    end
    else if (wr_isel)
    begin
      isel_r <= req.wdata; // see [R03] see [R04]
    end
  end

  // Event line 3 selector is read-only
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      esel_r <= {`VBIR_RST_EVT2, `VBIR_RST_EVT1, `VBIR_RST_EVT0};
      int8_r <= `VBIR_RST_INT8;
    end
    else if (wr_esel)
    begin
      esel_r <= req.wdata[`VBIR_ESEL_EVT_LSB +: 12]; // see [R06]
      int8_r <= req.wdata[`VBIR_ESEL_INT8_LSB +: 4]; // see [R07]
    end
  end

  // ------------------------------------------------------------
  // Memory select and mask
  // ------------------------------------------------------------
  // Bit 1 is stored as written, reserved one included, and drives resizer_memory_select
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      msel_r <= `VBIR_RST_MSEL;
    end
    else if (wr_msel)
    begin
      msel_r <= req.wdata[2:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      mask_r <= `VBIR_RST_MASK;
    end
    else if (wr_mask)
    begin
      mask_r <= req.wdata[VBIR_NSRC-1:0];
    end
  end

  assign mem_sel.pipe_write_align_ctl  = msel_r[`VBIR_MSEL_ALIGN]; // see [R08]
  assign mem_sel.resizer_memory_select = msel_r[`VBIR_MSEL_RSZ];   // see [R09]
  assign mem_sel.defect_memory_select  = msel_r[`VBIR_MSEL_DFC];   // see [R10]

  // ------------------------------------------------------------
  // Line routing
  // ------------------------------------------------------------
  // Lines follow the trigger, not the flag, so a held flag repeats nothing
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      int_nxt[i] = src_of(isel_r[4*i +: 4], src_trig); // see [R03] see [R04] see [R05] see [R12]
    end
    int_nxt[8] = src_of(int8_r, src_trig); // see [R07] see [R11]
    evt_nxt[3] = src_of(`VBIR_RST_EVT3, src_trig); // see [R06]
    for (int i = 0; i < 3; i++)
    begin
      evt_nxt[i] = src_of(esel_r[4*i +: 4], src_trig); // see [R06] see [R12]
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      int_line <= 9'h000;
      evt_line <= 4'h0;
    end
    else
    begin
      int_line <= int_nxt;
      evt_line <= evt_nxt;
    end
  end

  assign irq = |(flag_r & mask_r);

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    unique case (req.addr)
      `VBIR_OFS_FLAG: rdata_nxt = {19'h0, flag_r};
      `VBIR_OFS_ISEL: rdata_nxt = isel_r;
      `VBIR_OFS_ESEL: rdata_nxt = {`VBIR_RST_EVT3, esel_r, 12'h000, int8_r};
      `VBIR_OFS_MSEL: rdata_nxt = {29'h0, msel_r};
      `VBIR_OFS_MASK: rdata_nxt = {19'h0, mask_r};
      default:        rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rdata <= 32'h0000_0000;
    end
    else if (req.rd)
    begin
      rdata <= rdata_nxt;
    end
    else
    begin
      rdata <= 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_flag_set;
    @(posedge clk_sys) disable iff (!rst_n)
    (|src_trig) |=> ((flag_r & $past(src_trig)) == $past(src_trig));
  endproperty
  a_flag_set: assert property (p_flag_set) // see [R01]
    else $error("Triggered flag not set");

  property p_flag_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    (!wr_flag && (|flag_r)) |=> ((flag_r & $past(flag_r)) == $past(flag_r));
  endproperty
  a_flag_hold: assert property (p_flag_hold) // see [R01]
    else $error("Flag dropped without a clear");

  property p_flag_clear;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_flag && req.wdata[0] && !src_trig[0]) |=> !flag_r[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) // see [R02]
    else $error("Write one did not clear flag 0");

  property p_zero_keeps;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_flag && !req.wdata[5] && flag_r[5]) |=> flag_r[5];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) // see [R11]
    else $error("Write zero changed flag 5");

  property p_line7;
    @(posedge clk_sys) disable iff (!rst_n)
    ##1 int_line[7] == src_of($past(isel_r[31:28]), $past(src_trig));
  endproperty
  a_line7: assert property (p_line7) // see [R03]
    else $error("Line 7 does not follow its selector");

  property p_line6;
    @(posedge clk_sys) disable iff (!rst_n)
    (isel_r[27:24] == 4'h3 && src_trig[3]) |=> int_line[6];
  endproperty
  a_line6: assert property (p_line6) // see [R04]
    else $error("Line 6 missed its source");

  property p_code12;
    @(posedge clk_sys) disable iff (!rst_n)
    (isel_r[3:0] == 4'hc && src_trig[12]) |=> int_line[0];
  endproperty
  a_code12: assert property (p_code12) // see [R05]
    else $error("Code 12 not routed to pipe source 5");

  property p_unused;
    @(posedge clk_sys) disable iff (!rst_n)
    (isel_r[7:4] == `VBIR_CODE_UNUSED) |=> !int_line[1];
  endproperty
  a_unused: assert property (p_unused) // see [R11]
    else $error("Unused code drove line 1");

  property p_evt;
    @(posedge clk_sys) disable iff (!rst_n)
    ##1 (evt_line[2] == src_of($past(esel_r[11:8]), $past(src_trig))) && !evt_line[3];
  endproperty
  a_evt: assert property (p_evt) // see [R06]
    else $error("Event lines misrouted");

  property p_line8;
    @(posedge clk_sys) disable iff (!rst_n)
    ##1 int_line[8] == src_of($past(int8_r), $past(src_trig));
  endproperty
  a_line8: assert property (p_line8) // see [R07]
    else $error("Ninth line misrouted");

  property p_mem;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_msel |=> (mem_sel == vbir_mem_t'($past(req.wdata[2:0])));
  endproperty
  a_mem: assert property (p_mem) // see [R08] see [R09] see [R10]
    else $error("Memory select not taken");

  property p_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
    (isel_r[11:8] == 4'h4 && src_trig[4] && !wr_isel) ##1 !src_trig[4] |=> !int_line[2];
  endproperty
  a_pulse: assert property (p_pulse) // see [R12]
    else $error("Line 2 held past one cycle");

  property p_clear_any;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_flag |=> ~|(flag_r & $past(req.wdata[VBIR_NSRC-1:0] & ~src_trig));
  endproperty
  a_clear_any: assert property (p_clear_any) // see [R02]
    else $error("Written one left a flag set");

  property p_isel_take;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_isel |=> (isel_r == $past(req.wdata));
  endproperty
  a_isel_take: assert property (p_isel_take) // see [R03]
    else $error("Interrupt selectors not taken");

  property p_esel_take;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_esel |=> (esel_r == $past(req.wdata[27:16])) && (int8_r == $past(req.wdata[3:0]));
  endproperty
  a_esel_take: assert property (p_esel_take) // see [R06] see [R07]
    else $error("Event selectors not taken");

  property p_irq_set;
    @(posedge clk_sys) disable iff (!rst_n)
    (src_trig[4] && mask_r[4] && !wr_mask) |=> irq;
  endproperty
  a_irq_set: assert property (p_irq_set) // see [R01]
    else $error("Unmasked trigger raised no interrupt");

  property p_rd_flag;
    @(posedge clk_sys) disable iff (!rst_n)
    (req.rd && (req.addr == `VBIR_OFS_FLAG)) |=> (rdata == {19'h0, $past(flag_r)});
  endproperty
  a_rd_flag: assert property (p_rd_flag) // see [R01]
    else $error("Flag read returned stale data");

  property p_evt_unused;
    @(posedge clk_sys) disable iff (!rst_n)
    (esel_r[3:0] == `VBIR_CODE_UNUSED) |=> !evt_line[0];
  endproperty
  a_evt_unused: assert property (p_evt_unused) // see [R11]
    else $error("Unused code drove event line 0");

endmodule // vbir_top
`default_nettype wire

// ==== bench/vbir_line_sink.sv ====
// Purpose: Far-side sink for the interrupt and event lines
// Assumes: Lines are one-cycle pulses
// Notes:   Counts pulses and lines held high twice in a row
`default_nettype none
module vbir_line_sink
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [8:0] int_line,
  input  wire logic [3:0] evt_line,
  output int              n_seen,
  output int              n_stuck
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] last_r;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      n_seen  <= 0;
      n_stuck <= 0;
      last_r  <= '0;
    end
    else
    begin
      // Bench never triggers two cycles running, so a repeat is stuck
      n_seen  <= n_seen + $countones({int_line, evt_line});
      n_stuck <= n_stuck + $countones(last_r & {int_line, evt_line});
      last_r  <= {int_line, evt_line};
    end
  end
endmodule // vbir_line_sink
`default_nettype wire

// ==== bench/vbir_top_test.sv ====
// Purpose: Self-checking bench of the interrupt router
// Assumes: Register offsets from the shared header
// Notes:   Routing codes run from a table
`include "vbir_cfg.svh"
`default_nettype none
module vbir_top_test
  import vbir_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_sys = 1'b0;
  logic                 rst_n = 1'b0;
  vbir_req_t            req = '0;
  logic [VBIR_NSRC-1:0] src_trig = '0;
  logic [31:0]          rdata;
  logic [8:0]           int_line;
  logic [3:0]           evt_line;
  logic                 irq;
  vbir_mem_t            mem_sel;
  int                   n_fail, compares, exp_seen, n_seen, n_stuck;
  logic [17:0]          rows [16];
  logic [3:0]           c;
  logic [12:0]          t;
  logic                 h;

  vbir_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rdata(rdata),
    .src_trig(src_trig), .int_line(int_line), .evt_line(evt_line), .irq(irq),
    .mem_sel(mem_sel));
  vbir_line_sink i_sink (.clk_sys(clk_sys), .rst_n(rst_n), .int_line(int_line),
    .evt_line(evt_line), .n_seen(n_seen), .n_stuck(n_stuck));

  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ------
  // Bus and compare tasks
  // ------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk_sys);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask

  task automatic pulse(input logic [12:0] tr, input logic [8:0] ei, input logic [3:0] ee);
    @(posedge clk_sys);
    src_trig <= tr;
    @(posedge clk_sys);
    src_trig <= '0;
    #1;
    chk("int_line", {23'h0, ei}, {23'h0, int_line});
    chk("evt_line", {28'h0, ee}, {28'h0, evt_line});
    exp_seen += $countones({ei, ee});
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ------
  // Sequence
  // ------
  initial
  begin
    // Row: code, trigger, pulse expected
    rows = '{18'h00003, 18'h04005, 18'h08009, 18'h0c011, 18'h10021, 18'h14041,
      18'h18081, 18'h1c101, 18'h20201, 18'h24401, 18'h28801, 18'h2fffe,
      18'h32001, 18'h37ffe, 18'h3bffe, 18'h3fffe};
    repeat (20) @(posedge clk_sys);
    #1;
    chk("reset outputs", 32'h0, {15'h0, int_line, evt_line, irq, mem_sel});
    @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`VBIR_OFS_FLAG, 32'h0, "flags");
    rd(`VBIR_OFS_ISEL, `VBIR_RST_ISEL, "isel");
    rd(`VBIR_OFS_ESEL, 32'hdb830008, "esel");
    rd(`VBIR_OFS_MSEL, 32'h0, "msel");
    wr(8'h00, 32'hffffffff);
    rd(8'h00, 32'h0, "unmapped");
    foreach (rows[i])
    begin
      {c, t, h} = rows[i];
      wr(`VBIR_OFS_ISEL, {8{c}});
      wr(`VBIR_OFS_ESEL, {4'h0, c, c, c, 12'h000, c});
      pulse(t, {9{h}}, {1'b0, {3{h}}});
    end
    rd(`VBIR_OFS_FLAG, 32'h1fff, "flags set");
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`VBIR_OFS_FLAG, 32'h0);
    rd(`VBIR_OFS_FLAG, 32'h1fff, "zero write");
    wr(`VBIR_OFS_MASK, 32'h10);
    chk("irq on", 32'h1, {31'h0, irq});
    rd(`VBIR_OFS_MASK, 32'h10, "mask");
    wr(`VBIR_OFS_FLAG, 32'h8);
    rd(`VBIR_OFS_FLAG, 32'h1ff7, "clear one");
    wr(`VBIR_OFS_FLAG, 32'h10);
    chk("irq off", 32'h0, {31'h0, irq});
    wr(`VBIR_OFS_ISEL, 32'h4bbbbbb5);
    wr(`VBIR_OFS_ESEL, 32'h0bbb000b);
    pulse(13'h0010, 9'h080, 4'h0);
    pulse(13'h0020, 9'h001, 4'h0);
    wr(`VBIR_OFS_ESEL, 32'hffffffff);
    rd(`VBIR_OFS_ESEL, 32'hdfff000f, "esel fixed");
    wr(`VBIR_OFS_ESEL, 32'h0321000c);
    pulse(13'h0004, 9'h000, 4'h2);
    pulse(13'h1000, 9'h100, 4'h0);
    // Set and clear of one flag in the same cycle
    @(posedge clk_sys);
    req <= '{`VBIR_OFS_FLAG, 32'h20, 1'b1, 1'b0};
    src_trig <= 13'h0020;
    @(posedge clk_sys);
    req.wr <= 1'b0;
    src_trig <= '0;
    exp_seen += 1;
    rd(`VBIR_OFS_FLAG, 32'h1ff7, "set wins");
    wr(`VBIR_OFS_MSEL, 32'h5);
    chk("mem_sel", 32'h5, {29'h0, mem_sel});
    rd(`VBIR_OFS_MSEL, 32'h5, "msel");
    wr(`VBIR_OFS_MSEL, 32'hfffffffa);
    chk("mem_sel", 32'h2, {29'h0, mem_sel});
    rd(`VBIR_OFS_MSEL, 32'h2, "msel");
    chk("pulses", exp_seen, n_seen);
    chk("stuck", 32'h0, n_stuck);
    // Mid-run reset must bring every register back
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("reset again", 32'h0, {15'h0, int_line, evt_line, irq, mem_sel});
    @(posedge clk_sys);
    rst_n <= 1'b1;
    exp_seen = 0;
    rd(`VBIR_OFS_FLAG, 32'h0, "flags after reset");
    rd(`VBIR_OFS_ISEL, `VBIR_RST_ISEL, "isel after reset");
    rd(`VBIR_OFS_ESEL, 32'hdb830008, "esel after reset");
    pulse(13'h0008, 9'h008, 4'h1);
    rd(`VBIR_OFS_MASK, 32'h0, "mask after reset");
    chk("pulses after reset", exp_seen, n_seen);
    results();
  end

  // Whole run is under 1000 cycles; four times that means a hang
  initial
  begin
    #20000;
    n_fail++;
    results();
  end
endmodule // vbir_top_test
`default_nettype wire
